/* File: design/dscp_priority_map_table.v */
/*
 Code point to priority map table with APB register access.
 Nine byte registers at indices 0x90 to 0x98 feed a lookup of the six-bit
 code point taken from bits 7:2 of a TOS or traffic class byte.
 Assumes an APB master on mclk and a classifier that presents one
 TOS or traffic class byte with a one-cycle valid strobe.
 Assumes a master that holds each request until pready is sampled high.
*/
`timescale 1ns/1ps
`include "dscp_map_defs.vh"

// Functional notes
// - Code point 0 uses first register bits 1:0
// - Code point 1 uses first register bits 3:2
// - Code points 2,3 use bits 5:4, 7:6
// - Register 0x91 maps code points 4 to 7
// - Register 0x92 maps code points 8 to 11
// - Register 0x93 maps code points 12 to 15
// - Register 0x94 maps code points 16 to 19
// - Register 0x95 maps code points 20 to 23
// - Register 0x96 maps code points 24 to 27
// - Eighth register maps code points 28 to 31
// - Ninth register bits 7:6 map code point 35
module dscp_priority_map_table (
    input wire mclk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire tos_valid,
    input wire [7:0] tos_byte,
    output reg prio_valid_r,
    output reg [1:0] prio_r,
    output reg prio_hit_r
);
    // Register port phases
    localparam ST_IDLE = 1'b0;
    localparam ST_ANSWER = 1'b1;

    wire [9:0] word_idx;
    wire aligned;
    wire mapped;
    wire setup;
    wire access;
    wire wr_go;
    wire [71:0] map_flat;

    // One byte per register, named after the code points it maps
    wire [7:0] dscp_map_codes_00_03;
    wire [7:0] dscp_map_codes_04_07;
    wire [7:0] dscp_map_codes_08_0b;
    wire [7:0] dscp_map_codes_0c_0f;
    wire [7:0] dscp_map_codes_10_13;
    wire [7:0] dscp_map_codes_14_17;
    wire [7:0] dscp_map_codes_18_1b;
    wire [7:0] dscp_map_codes_1c_1f;
    wire [7:0] dscp_map_codes_20_23;

    wire [1:0] prio_nxt;
    wire hit_nxt;
    reg state_r;
    reg state_nxt;
    reg [`NUM_MAP_REGS-1:0] wr_sel;
    reg [7:0] rd_byte;

    assign word_idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign mapped = aligned && (word_idx >= {2'h0, `IDX_FIRST}) &&
        (word_idx <= {2'h0, `IDX_LAST});
    assign setup = psel && !penable;
    // A write lands only at the edge where the master samples pready high
    assign access = (state_r == ST_ANSWER) && psel && penable;
    assign wr_go = access && pwrite && mapped;

    // One answer per setup with no wait states, so the master never stalls
    always @* begin
        state_nxt = ST_IDLE;
        case (state_r)
            ST_IDLE: begin
                if (setup) begin
                    state_nxt = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                // A master that skips the access phase is still answered
                if (setup) begin
                    state_nxt = ST_ANSWER;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Answer phase register; pready is its twin so the port comes from a flop
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Address decode by index; unaligned or unmapped words select nothing
    always @* begin
        wr_sel = 9'h000;
        if (!wr_go) begin
            wr_sel = 9'h000;
        end else if (word_idx == {2'h0, `IDX_CODES_00_03}) begin
            wr_sel = 9'h001;
        end else if (word_idx == {2'h0, `IDX_CODES_04_07}) begin
            wr_sel = 9'h002;
        end else if (word_idx == {2'h0, `IDX_CODES_08_0B}) begin
            wr_sel = 9'h004;
        end else if (word_idx == {2'h0, `IDX_CODES_0C_0F}) begin
            wr_sel = 9'h008;
        end else if (word_idx == {2'h0, `IDX_CODES_10_13}) begin
            wr_sel = 9'h010;
        end else if (word_idx == {2'h0, `IDX_CODES_14_17}) begin
            wr_sel = 9'h020;
        end else if (word_idx == {2'h0, `IDX_CODES_18_1B}) begin
            wr_sel = 9'h040;
        end else if (word_idx == {2'h0, `IDX_CODES_1C_1F}) begin
            wr_sel = 9'h080;
        end else if (word_idx == {2'h0, `IDX_CODES_20_23}) begin
            wr_sel = 9'h100;
        end else begin
            wr_sel = 9'h000;
        end
    end

    // Refused reads return zero so software never sees a stale byte
    always @* begin
        rd_byte = 8'h00;
        if (!aligned) begin
            rd_byte = 8'h00;
        end else if (word_idx == {2'h0, `IDX_CODES_00_03}) begin
            rd_byte = dscp_map_codes_00_03;
        end else if (word_idx == {2'h0, `IDX_CODES_04_07}) begin
            rd_byte = dscp_map_codes_04_07;
        end else if (word_idx == {2'h0, `IDX_CODES_08_0B}) begin
            rd_byte = dscp_map_codes_08_0b;
        end else if (word_idx == {2'h0, `IDX_CODES_0C_0F}) begin
            rd_byte = dscp_map_codes_0c_0f;
        end else if (word_idx == {2'h0, `IDX_CODES_10_13}) begin
            rd_byte = dscp_map_codes_10_13;
        end else if (word_idx == {2'h0, `IDX_CODES_14_17}) begin
            rd_byte = dscp_map_codes_14_17;
        end else if (word_idx == {2'h0, `IDX_CODES_18_1B}) begin
            rd_byte = dscp_map_codes_18_1b;
        end else if (word_idx == {2'h0, `IDX_CODES_1C_1F}) begin
            rd_byte = dscp_map_codes_1c_1f;
        end else if (word_idx == {2'h0, `IDX_CODES_20_23}) begin
            rd_byte = dscp_map_codes_20_23;
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Nine map registers; each keeps its byte until software rewrites it
    // Codes 0x00 to 0x03
    map_entry_reg u_codes_00_03 (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(wr_sel[0]),
        .wr_data(pwdata[7:0]),
        .value_r(dscp_map_codes_00_03)
    );

    // Codes 0x04 to 0x07
    map_entry_reg u_codes_04_07 (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(wr_sel[1]),
        .wr_data(pwdata[7:0]),
        .value_r(dscp_map_codes_04_07)
    );

    // Codes 0x08 to 0x0b
    map_entry_reg u_codes_08_0b (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(wr_sel[2]),
        .wr_data(pwdata[7:0]),
        .value_r(dscp_map_codes_08_0b)
    );

    // Codes 0x0c to 0x0f
    map_entry_reg u_codes_0c_0f (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(wr_sel[3]),
        .wr_data(pwdata[7:0]),
        .value_r(dscp_map_codes_0c_0f)
    );

    // Codes 0x10 to 0x13
    map_entry_reg u_codes_10_13 (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(wr_sel[4]),
        .wr_data(pwdata[7:0]),
        .value_r(dscp_map_codes_10_13)
    );

    // Codes 0x14 to 0x17
    map_entry_reg u_codes_14_17 (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(wr_sel[5]),
        .wr_data(pwdata[7:0]),
        .value_r(dscp_map_codes_14_17)
    );

    // Codes 0x18 to 0x1b
    map_entry_reg u_codes_18_1b (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(wr_sel[6]),
        .wr_data(pwdata[7:0]),
        .value_r(dscp_map_codes_18_1b)
    );

    // Codes 0x1c to 0x1f
    map_entry_reg u_codes_1c_1f (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(wr_sel[7]),
        .wr_data(pwdata[7:0]),
        .value_r(dscp_map_codes_1c_1f)
    );

    // Codes 0x20 to 0x23
    map_entry_reg u_codes_20_23 (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(wr_sel[8]),
        .wr_data(pwdata[7:0]),
        .value_r(dscp_map_codes_20_23)
    );

    // Four entries per byte, lowest code point in the low bits of each byte;
    // the lookup indexes this vector directly by twice the code point
    assign map_flat = {
        dscp_map_codes_20_23,
        dscp_map_codes_1c_1f,
        dscp_map_codes_18_1b,
        dscp_map_codes_14_17,
        dscp_map_codes_10_13,
        dscp_map_codes_0c_0f,
        dscp_map_codes_08_0b,
        dscp_map_codes_04_07,
        dscp_map_codes_00_03
    };

    // pready and pslverr stand for the one access cycle; prdata until next setup.
    // Read data is captured at setup, when no write can still be pending.
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= (state_nxt == ST_ANSWER);
            pslverr <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata <= {24'h00_0000, rd_byte};
            end else if (setup) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Lookup uses current table, so a write affects frames that follow it
    // Code points above the table report a miss with priority zero
    prio_select u_sel (
        .map_flat(map_flat),
        .code(tos_byte[`CP_HI:`CP_LO]),
        .prio(prio_nxt),
        .hit(hit_nxt)
    );

    // Priority and hit hold between frames for a slow consumer
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prio_valid_r <= 1'b0;
            prio_r <= 2'h0;
            prio_hit_r <= 1'b0;
        end else begin
            prio_valid_r <= tos_valid;
            if (tos_valid) begin
                prio_r <= prio_nxt;
                prio_hit_r <= hit_nxt;
            end
        end
    end
endmodule // dscp_priority_map_table

/* File: design/dscp_map_defs.vh */
/*
 Offsets, reset value and field layout for the code point priority map.
 Assumes inclusion by the map register and lookup design files.
*/
`ifndef DSCP_MAP_DEFS_VH
`define DSCP_MAP_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_CODES_00_03 8'h90
`define IDX_CODES_04_07 8'h91
`define IDX_CODES_08_0B 8'h92
`define IDX_CODES_0C_0F 8'h93
`define IDX_CODES_10_13 8'h94
`define IDX_CODES_14_17 8'h95
`define IDX_CODES_18_1B 8'h96
`define IDX_CODES_1C_1F 8'h97
`define IDX_CODES_20_23 8'h98
`define IDX_FIRST 8'h90
`define IDX_LAST 8'h98
`define NUM_MAP_REGS 9
`define MAP_RESET 8'h00
`define CODE_LAST 6'h23
`define PRIO_MISS 2'h0
`define CP_HI 7
`define CP_LO 2

`endif

/* File: design/map_entry_reg.v */
/*
 One 8-bit map register holding four 2-bit priorities.
 Assumes a single clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "dscp_map_defs.vh"

module map_entry_reg (
    input wire mclk,
    input wire nrst,
    input wire wr_en,
    input wire [7:0] wr_data,
    output reg [7:0] value_r
);
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            value_r <= `MAP_RESET;
        end else if (wr_en) begin
            value_r <= wr_data;
        end
    end
endmodule // map_entry_reg

/* File: design/prio_select.v */
/*
 Picks the 2-bit priority for a code point from the flattened map.
 Assumes the map vector packs four code points per byte, lowest in bits 1:0.
*/
`timescale 1ns/1ps
`include "dscp_map_defs.vh"

module prio_select (
    input wire [71:0] map_flat,
    input wire [5:0] code,
    output reg [1:0] prio,
    output reg hit
);
    reg [6:0] bitpos;
    always @* begin
        bitpos = {code, 1'b0};
        hit = (code <= `CODE_LAST);
        if (hit) begin
            prio = map_flat[bitpos +: 2];
        end else begin
            prio = `PRIO_MISS;
        end
    end
endmodule // prio_select

/* File: testbench/map_table_assertions.sv */
/* Port checker for the code point map table.
 Assumes the bind below and the define header on the include path. */
`timescale 1ns/1ps
`include "dscp_map_defs.vh"
module map_table_checks (
    input wire mclk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire tos_valid,
    input wire [7:0] tos_byte,
    input wire prio_valid_r,
    input wire [1:0] prio_r,
    input wire prio_hit_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence miss_s;
        tos_valid && tos_byte[7:2] > `CODE_LAST;
    endsequence
    apb_answer_a: assert property (setup_s |=> pready) else $error("late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("long");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray err");
    read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper bits");
    prio_lat_a: assert property (tos_valid |=> prio_valid_r) else $error("no prio");
    prio_cause_a: assert property (prio_valid_r |-> $past(tos_valid)) else $error("odd");
    miss_zero_a: assert property (miss_s |=> !prio_hit_r && prio_r == 2'h0)
        else $error("miss");
    hit_set_a: assert property (tos_valid && tos_byte[7:2] <= `CODE_LAST |=> prio_hit_r)
        else $error("hit");
    prio_hold_a: assert property (!tos_valid |=> $stable(prio_r)) else $error("moved");
endmodule // map_table_checks
bind dscp_priority_map_table map_table_checks chk (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tos_valid(tos_valid), .tos_byte(tos_byte), .prio_valid_r(prio_valid_r),
    .prio_r(prio_r), .prio_hit_r(prio_hit_r));

/* File: testbench/dscp_priority_map_table_tb.sv */
/* Random and corner tests of the map table over APB and lookup ports.
 Assumes the checker is bound in from its own file. */
`timescale 1ns/1ps
`include "dscp_map_defs.vh"
module dscp_priority_map_table_tb;
    reg mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, tos_valid = 0, err;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0, rd;
    reg [7:0] tos_byte = 8'h0;
    reg [7:0] map [0:8];
    wire [31:0] prdata;
    wire pready, pslverr, prio_valid_r, prio_hit_r;
    wire [1:0] prio_r;
    integer fails = 0, n_checks = 0, cyc = 0, i;
    dscp_priority_map_table uut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tos_valid(tos_valid), .tos_byte(tos_byte),
        .prio_valid_r(prio_valid_r), .prio_r(prio_r), .prio_hit_r(prio_hit_r));
    always #50 mclk = ~mclk;
    // Whole run is about 265 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails = fails + 1;
            results;
        end
    end
    task check(input [31:0] seen, input [31:0] exp, input [95:0] what);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("wrong value %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // Request held until pready is sampled high
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
            @(posedge mclk);
            penable <= 1'b1;
            @(posedge mclk);
            while (pready !== 1'b1) @(posedge mclk);
            {rd, err} = {prdata, pslverr};
            {psel, penable} <= 2'b00;
        end
    endtask
    function [11:0] addr(input [7:0] k);
        addr = {2'h0, `IDX_FIRST + k, 2'h0};
    endfunction
    function [2:0] want(input [5:0] cp);
        want = (cp > `CODE_LAST) ? 3'h0 : {1'b1, map[cp[5:2]][cp[1:0] * 2 +: 2]};
    endfunction
    task results;
        begin
            $display("checks %0d mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        rd = $urandom(41);
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        for (i = 0; i < 9; i = i + 1) begin
            apb(1'b0, addr(i), 32'h0);
            check(rd, `MAP_RESET, "reset");
            // Distinct fields in the first word expose swapped selects
            map[i] = (i == 0) ? 8'he4 : 8'($urandom);
            apb(1'b1, addr(i), {24'($urandom), map[i]});
            apb(1'b0, addr(i), 32'h0);
            check(rd, map[i], "readback");
            check(err, 1'b0, "okay");
        end
        $display("register test done");
        for (i = 0; i < 64; i = i + 1) begin
            @(posedge mclk);
            {tos_valid, tos_byte} <= {1'b1, i[5:0], 2'($urandom)};
            @(posedge mclk);
            tos_valid <= 1'b0;
            #1 check({prio_valid_r, prio_hit_r, prio_r}, {1'b1, want(i)}, "prio");
        end
        // Write then look up at once: the new entry must already be in use
        map[1] = map[1] ^ 8'h0c;
        apb(1'b1, addr(1), {24'h00_0000, map[1]});
        {tos_valid, tos_byte} <= {1'b1, 6'h05, 2'h3};
        @(posedge mclk);
        tos_valid <= 1'b0;
        #1 check({prio_valid_r, prio_hit_r, prio_r}, {1'b1, want(6'h05)}, "fresh");
        $display("lookup test done");
        apb(1'b1, 12'h241, 32'hff);
        check(err, 1'b1, "slverr");
        apb(1'b0, addr(0), 32'h0);
        check(rd, map[0], "unaligned");
        apb(1'b0, 12'h264, 32'h0);
        check(err, 1'b1, "unmapped");
        check(rd, 32'h0, "unmapped rd");
        $display("refusal test done");
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        check({prio_valid_r, prio_hit_r, prio_r}, 4'h0, "reset prio");
        nrst <= 1'b1;
        for (i = 0; i < 9; i = i + 1) begin
            apb(1'b0, addr(i), 32'h0);
            check(rd, `MAP_RESET, "reset again");
        end
        $display("mid-run reset test done");
        results;
    end
endmodule // dscp_priority_map_table_tb
